//--- bench/msc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// pin timing checks on the sequencer top
module msc_asserts
  import msc_pkg::*;
#(
  parameter int INIT_CYCLES = 50
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic module_select_n_i,
  input wire logic low_power_request_i,
  input wire logic [NUM_LANES-1:0] rx_los_i,
  input wire logic [NUM_LANES-1:0] tx_fault_i,
  input wire logic interrupt_out_n_o,
  input wire logic data_not_ready_o,
  input wire logic bus_enable_o,
  input wire logic low_power_o,
  input wire logic [NUM_FLAGS-1:0] flags_o,
  input wire logic [NUM_FLAGS-1:0] mask_o,
  input wire logic pdown_o
);
  // init count plus synchroniser and register slack
  localparam int LATE = INIT_CYCLES + 8;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // init end seen on the status pin
  sequence s_ready;
    $fell(data_not_ready_o);
  endsequence
  // some unmasked flag pending
  sequence s_pending;
    (|(flags_o & ~mask_o));
  endsequence
  a_ready_int: assert property (s_ready |=> !interrupt_out_n_o)
    else $error("interrupt missing after ready");
  a_init_time: assert property ($rose(nrst_i) |-> ##[1:LATE] !data_not_ready_o)
    else $error("init too slow");
  a_int_hold: assert property (s_pending [*3] |-> !interrupt_out_n_o)
    else $error("interrupt released with flag pending");
  a_int_free: assert property (!(|(flags_o & ~mask_o)) [*3] |-> interrupt_out_n_o)
    else $error("interrupt held without flag");
  a_los_flag: assert property ($rose(rx_los_i[0]) && !data_not_ready_o |-> ##[1:6] flags_o[0])
    else $error("loss flag late");
  a_fault_flag: assert property ($rose(tx_fault_i[0]) && !data_not_ready_o |-> ##[1:6] flags_o[4])
    else $error("fault flag late");
  a_lp_pin: assert property ($rose(low_power_request_i) |-> ##[1:6] low_power_o)
    else $error("low power pin ignored");
  a_pdown_on: assert property ($rose(pdown_o) |-> ##[0:2] low_power_o)
    else $error("power down bit ignored");
  a_sel_on: assert property ($fell(module_select_n_i) && !data_not_ready_o |-> ##[1:6] bus_enable_o)
    else $error("bus not enabled");
  a_sel_off: assert property ($rose(module_select_n_i) |-> ##[1:6] !bus_enable_o)
    else $error("bus not silenced");
  a_bus_quiet: assert property (data_not_ready_o [*2] |-> !bus_enable_o)
    else $error("bus enabled before ready");
endmodule
`default_nettype wire

//--- bench/msc_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side: reset pin, bus waveform and bus engine strobes
module msc_host
  import msc_pkg::*;
(
  input wire logic mclk_i,
  output logic module_reset_n_o,
  output logic scl_o,
  output logic sda_o,
  output logic [NUM_FLAGS-1:0] flag_read_o,
  output logic [NUM_FLAGS-1:0] mask_wr_o,
  output logic pdown_wr_o
);
  localparam realtime HALF = 62.5; // half of the 125 ns link period
  initial begin
    module_reset_n_o = 1'h1;
    scl_o = 1'h1; // pulled up, clock stands still outside frames
    sda_o = 1'h1;
    flag_read_o = 9'h000;
    mask_wr_o = 9'h000;
    pdown_wr_o = 1'h0;
  end
  // reset pin pulse of n cycles; a real reset needs at least 201
  task automatic pulse(input int n);
    @(negedge mclk_i);
    module_reset_n_o = 1'h0;
    repeat (n) @(negedge mclk_i);
    module_reset_n_o = 1'h1;
  endtask
  // one frame: read strobe, start, one bit, stop, then the commit fall
  task automatic xfer(input logic [NUM_FLAGS-1:0] rd, input logic [NUM_FLAGS-1:0] mk, input logic pd);
    @(negedge mclk_i);
    flag_read_o = rd;
    mask_wr_o = mk;
    pdown_wr_o = pd;
    @(negedge mclk_i);
    flag_read_o = 9'h000; // one strobe only, so no stale read leaks into later commits
    sda_o = 1'h0;
    #HALF scl_o = 1'h0;
    #HALF scl_o = 1'h1;
    #HALF sda_o = 1'h1;
    #HALF scl_o = 1'h0;
    #HALF scl_o = 1'h1;
    repeat (8) @(negedge mclk_i);
  endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// scenario bench for the sequencer with a host model
module testbench;
  import msc_pkg::*;
  localparam int INIT_CYCLES = 50; // shortened init count
  logic mclk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic ce_i = 1'h1;
  logic module_select_n_i = 1'h0;
  logic low_power_request_i = 1'h0;
  logic [NUM_LANES-1:0] rx_los_i = 4'h0;
  logic [NUM_LANES-1:0] tx_fault_i = 4'h0;
  logic module_reset_n_i, scl_i, sda_i, pdown_wr_i;
  logic [NUM_FLAGS-1:0] flag_read_i, mask_wr_i;
  logic interrupt_out_n_o, module_present_n_o, data_not_ready_o, bus_enable_o, low_power_o, pdown_o;
  logic [NUM_FLAGS-1:0] flags_o, mask_o;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  msc_top #(.INIT_CYCLES(INIT_CYCLES)) msc_top_i (.mclk_i, .nrst_i, .ce_i, .module_reset_n_i,
    .module_select_n_i, .low_power_request_i, .scl_i, .sda_i, .rx_los_i, .tx_fault_i, .flag_read_i,
    .mask_wr_i, .pdown_wr_i, .interrupt_out_n_o, .module_present_n_o, .data_not_ready_o, .bus_enable_o,
    .low_power_o, .flags_o, .mask_o, .pdown_o);
  msc_host msc_host_i (.mclk_i, .module_reset_n_o(module_reset_n_i), .scl_o(scl_i), .sda_o(sda_i),
    .flag_read_o(flag_read_i), .mask_wr_o(mask_wr_i), .pdown_wr_o(pdown_wr_i));
  // clock
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  // hang guard, far above the roughly 1250 cycles needed
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // init end: ready flag, interrupt, bus open, then read clears it
  task automatic t_init;
    for (int i = 0; i < INIT_CYCLES + 20 && data_not_ready_o !== 1'h0; i++) w(1);
    w(2);
    check(9'(data_not_ready_o), 9'h000);
    check(flags_o, 9'h100);
    check(9'(interrupt_out_n_o), 9'h000);
    check(9'(bus_enable_o), 9'h001);
    check(9'(module_present_n_o), 9'h000);
    msc_host_i.xfer(9'h100, 9'h000, 1'h0);
    check(9'(interrupt_out_n_o), 9'h001);
  endtask
  // every loss and fault lane sets its flag, read releases it
  task automatic t_flags;
    for (int b = 0; b < 8; b++) begin
      if (b < 4) rx_los_i[b] = 1'h1;
      else tx_fault_i[b-4] = 1'h1;
      w(6);
      check(9'(flags_o[b]), 9'h001);
      check(9'(interrupt_out_n_o), 9'h000);
      msc_host_i.xfer(9'h001 << b, 9'h000, 1'h0);
      check(9'(flags_o[b]), 9'h000);
      check(9'(interrupt_out_n_o), 9'h001);
    end
  endtask
  // masked flag stays silent until the mask is lifted
  task automatic t_mask;
    rx_los_i[0] = 1'h0;
    msc_host_i.xfer(9'h000, 9'h001, 1'h0);
    check(mask_o, 9'h001);
    rx_los_i[0] = 1'h1;
    w(6);
    check(9'(flags_o[0]), 9'h001);
    check(9'(interrupt_out_n_o), 9'h001);
    msc_host_i.xfer(9'h000, 9'h000, 1'h0);
    check(9'(interrupt_out_n_o), 9'h000);
    msc_host_i.xfer(9'h001, 9'h000, 1'h0);
    check(9'(interrupt_out_n_o), 9'h001);
  endtask
  // low power by pin and by control bit
  task automatic t_power;
    low_power_request_i = 1'h1;
    w(6);
    check(9'(low_power_o), 9'h001);
    low_power_request_i = 1'h0;
    w(6);
    check(9'(low_power_o), 9'h000);
    msc_host_i.xfer(9'h000, 9'h000, 1'h1);
    check(9'(pdown_o), 9'h001);
    check(9'(low_power_o), 9'h001);
    msc_host_i.xfer(9'h000, 9'h000, 1'h0);
    check(9'(low_power_o), 9'h000);
  endtask
  // select gates the bus both ways
  task automatic t_select;
    module_select_n_i = 1'h1;
    w(6);
    check(9'(bus_enable_o), 9'h000);
    module_select_n_i = 1'h0;
    w(6);
    check(9'(bus_enable_o), 9'h001);
  endtask
  // clock enable low holds every state, then the block catches up
  task automatic t_freeze;
    ce_i = 1'h0;
    low_power_request_i = 1'h1;
    w(3);
    check(9'(low_power_o), 9'h000);
    ce_i = 1'h1;
    w(6);
    check(9'(low_power_o), 9'h001);
    low_power_request_i = 1'h0;
    w(6);
    check(9'(low_power_o), 9'h000);
  endtask
  // short pulse ignored, long pulse reinitialises and mutes the bus
  task automatic t_modreset;
    msc_host_i.pulse(150);
    w(6);
    check(9'(data_not_ready_o), 9'h000);
    msc_host_i.pulse(250);
    check(9'(data_not_ready_o), 9'h001);
    check(9'(bus_enable_o), 9'h000);
    msc_host_i.xfer(9'h000, 9'h0FF, 1'h0);
    check(mask_o, 9'h000);
    w(INIT_CYCLES + 10);
    check(9'(data_not_ready_o), 9'h000);
    check(9'(interrupt_out_n_o), 9'h000);
  endtask
  initial begin
    w(10);
    nrst_i = 1'h1;
    t_init();
    t_flags();
    t_mask();
    t_power();
    t_select();
    t_freeze();
    t_modreset();
    test_done();
  end
endmodule
bind msc_top msc_asserts #(.INIT_CYCLES(INIT_CYCLES)) msc_asserts_i (.mclk_i, .nrst_i, .module_select_n_i,
  .low_power_request_i, .rx_los_i, .tx_fault_i, .interrupt_out_n_o, .data_not_ready_o, .bus_enable_o,
  .low_power_o, .flags_o, .mask_o, .pdown_o);
`default_nettype wire

//--- src/msc_pkg.sv
// shared constants for the module control and status sequencer
package msc_pkg;

  // clock period of mclk_i in ns
  localparam int CLK_PERIOD_NS = 10;

  // lanes and flag layout
  localparam int NUM_LANES = 4;
  localparam int NUM_FLAGS = 9;
  localparam int FLAG_LOS_BASE = 0;
  localparam int FLAG_FAULT_BASE = 4;
  localparam int FLAG_INIT_BIT = 8;

  // data-not-ready status position in the memory map (byte 2, bit 0)
  localparam int DNR_BYTE = 2;
  localparam int DNR_BIT = 0;

  // pin synchroniser layout: control pins, bus pins, then lane conditions
  localparam int SYNC_W = 13;
  localparam int SYN_RESET = 0;
  localparam int SYN_SELECT = 1;
  localparam int SYN_LPREQ = 2;
  localparam int SYN_SCL = 3;
  localparam int SYN_SDA = 4;
  localparam int SYN_LOS_BASE = 5;
  localparam int SYN_FAULT_BASE = 9;

  // reset values
  localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 9'h000;
  localparam logic [NUM_FLAGS-1:0] MASK_RST = 9'h000;
  localparam logic PDOWN_RST = 1'b0;

  // timing: least reset pulse rounds up, init deadline rounds down
  localparam int T_RESET_MIN_US = 2;
  localparam int T_INIT_MS = 2000;
  localparam int RESET_MIN_CYC = (T_RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYC = (T_INIT_MS * 1000000) / CLK_PERIOD_NS;

  // deadlines the logic meets by reacting within a few cycles
  localparam int T_LOW_POWER_REQUEST_US = 100;
  localparam int T_INT_ASSERT_MS = 200;
  localparam int T_INT_DEASSERT_US = 500;
  localparam int T_LOS_MS = 100;
  localparam int T_FLAG_MS = 200;
  localparam int T_MASK_MS = 100;
  localparam int T_SELECT_US = 100;
  localparam int T_PDOWN_ON_MS = 100;
  localparam int T_PDOWN_OFF_MS = 300;

  // counter width, wide enough for the init count
  localparam int TIMER_W = 28;

  // sequencer states
  typedef enum logic [1:0] {
    MSC_INIT,
    MSC_HELD,
    MSC_RUN
  } msc_state_e;

endpackage

//--- src/msc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser, one chain per bit
module msc_sync
  import msc_pkg::*;
#(
  parameter int WIDTH = SYNC_W,
  parameter logic [SYNC_W-1:0] RST_VAL = 13'h0007
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta; // first stage, read only by the second
      logic stab; // second stage
      // resets to the idle level so no false edge follows reset
      always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
          meta <= RST_VAL[g];
          stab <= RST_VAL[g];
        end else if (ce_i) begin
          meta <= async_i[g];
          stab <= meta;
        end
      end
      assign sync_o[g] = stab;
    end
  endgenerate

endmodule
`default_nettype wire

//--- src/msc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// loadable down counter, flags expiry while it stands at zero
module msc_timer
  import msc_pkg::*;
#(
  parameter logic [TIMER_W-1:0] RST_COUNT = 28'h0000001
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [TIMER_W-1:0] count_i,
  input wire logic run_i,
  output logic expired_o
);

  logic [TIMER_W-1:0] cnt; // cycles left

  // count down while running; load has priority
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      cnt <= RST_COUNT;
    end else if (ce_i) begin
      if (load_i) begin
        cnt <= count_i;
      end else if (run_i && cnt != '0) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  // expiry stays up at zero so the user may act on it later
  assign expired_o = (cnt == '0);

endmodule
`default_nettype wire

//--- src/msc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - fully functional within 2000 ms of reset
// - reset counts only if low 2 us
// - answer bus within 2000 ms of power-on
// - clear data-not-ready, assert interrupt by 2000 ms
// - low-power pin lowers power within 100 us
// - interrupt low within 200 ms of condition
// - read clears flag, interrupt released within 500 us
// - loss-of-signal flag and interrupt within 100 ms
// - other flags and interrupt within 200 ms
// - mask set inhibits interrupt within 100 ms
// - mask cleared resumes interrupt within 100 ms
// - select asserted, bus answers within 100 us
// - select released, bus silent within 100 us
// - power-down bit lowers power within 100 ms
// - power-down cleared, full function within 300 ms
module msc_top
  import msc_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYC // shorten in simulation
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic module_reset_n_i,
  input wire logic module_select_n_i,
  input wire logic low_power_request_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [NUM_LANES-1:0] rx_los_i,
  input wire logic [NUM_LANES-1:0] tx_fault_i,
  input wire logic [NUM_FLAGS-1:0] flag_read_i,
  input wire logic [NUM_FLAGS-1:0] mask_wr_i,
  input wire logic pdown_wr_i,
  output logic interrupt_out_n_o,
  output logic module_present_n_o,
  output logic data_not_ready_o,
  output logic bus_enable_o,
  output logic low_power_o,
  output logic [NUM_FLAGS-1:0] flags_o,
  output logic [NUM_FLAGS-1:0] mask_o,
  output logic pdown_o
);

  // synchronised pins
  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins;
  logic reset_n_s; // module reset pin, synchronised
  logic select_n_s; // module select pin, synchronised
  logic lp_req_s; // low-power pin, synchronised
  logic scl_s;
  logic sda_s;
  logic [NUM_LANES-1:0] los_s;
  logic [NUM_LANES-1:0] fault_s;

  // bus edge tracking
  logic scl_d; // previous scl sample
  logic sda_d; // previous sda sample
  logic stop_seen; // stop bit seen, waiting for next scl fall
  logic commit; // one-cycle: falling scl after a stop
  logic [NUM_FLAGS-1:0] read_acc; // flags read in the current transaction

  // reset qualification and initialisation
  msc_state_e state;
  msc_state_e next_state;
  logic rst_qual_exp; // reset pin low long enough
  logic rst_qualified; // a valid reset pulse is in progress
  logic init_exp; // init time used up
  logic init_load;

  // flags and their causes
  logic [NUM_LANES-1:0] los_d;
  logic [NUM_LANES-1:0] fault_d;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] mask;
  logic pdown;
  logic init_done_pulse;

  // pin assembly for the synchroniser
  assign pins_async = {tx_fault_i, rx_los_i, sda_i, scl_i, low_power_request_i,
                       module_select_n_i, module_reset_n_i};

  // every pin passes two flops before use
  msc_sync #(
    .WIDTH(SYNC_W),
    .RST_VAL(13'h001B)
  ) u_sync (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .async_i(pins_async),
    .sync_o(pins)
  );

  assign reset_n_s = pins[SYN_RESET];
  assign select_n_s = pins[SYN_SELECT];
  assign lp_req_s = pins[SYN_LPREQ];
  assign scl_s = pins[SYN_SCL];
  assign sda_s = pins[SYN_SDA];
  assign los_s = pins[SYN_LOS_BASE +: NUM_LANES];
  assign fault_s = pins[SYN_FAULT_BASE +: NUM_LANES];

  // reset pulse width: reloaded while pin is high, counts while low
  msc_timer #(
    .RST_COUNT(TIMER_W'(RESET_MIN_CYC))
  ) u_rst_timer (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .load_i(reset_n_s),
    .count_i(TIMER_W'(RESET_MIN_CYC)),
    .run_i(!reset_n_s),
    .expired_o(rst_qual_exp)
  );

  // a short glitch never reaches expiry, so it is ignored
  assign rst_qualified = !reset_n_s && rst_qual_exp;

  // init timer restarts on the rising edge that ends a valid reset
  assign init_load = (state == MSC_HELD) && reset_n_s;

  // power-on starts the init count straight out of reset
  msc_timer #(
    .RST_COUNT(TIMER_W'(INIT_CYCLES))
  ) u_init_timer (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .load_i(init_load),
    .count_i(TIMER_W'(INIT_CYCLES)),
    .run_i(state == MSC_INIT),
    .expired_o(init_exp)
  );

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      MSC_INIT: begin
        if (rst_qualified) begin
          next_state = MSC_HELD;
        end else if (init_exp) begin
          next_state = MSC_RUN;
        end
      end
      MSC_HELD: begin
        if (reset_n_s) begin
          next_state = MSC_INIT;
        end
      end
      MSC_RUN: begin
        if (rst_qualified) begin
          next_state = MSC_HELD;
        end
      end
      default: begin
        next_state = MSC_INIT;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state <= MSC_INIT;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // the one cycle in which init completes
  assign init_done_pulse = (state == MSC_INIT) && (next_state == MSC_RUN);

  // stop bit detection on the management bus
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (ce_i) begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // bus writes and read-clears take effect at the scl fall after the stop
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      stop_seen <= 1'b0;
    end else if (ce_i) begin
      if (state != MSC_RUN) begin
        stop_seen <= 1'b0;
      end else if (scl_s && sda_s && !sda_d) begin
        stop_seen <= 1'b1;
      end else if (scl_d && !scl_s) begin
        stop_seen <= 1'b0;
      end
    end
  end

  assign commit = stop_seen && scl_d && !scl_s;

  // collect which flags the host read during this transaction
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      read_acc <= FLAGS_RST;
    end else if (ce_i) begin
      if (state != MSC_RUN || commit) begin
        read_acc <= FLAGS_RST;
      end else begin
        read_acc <= read_acc | flag_read_i;
      end
    end
  end

  // previous lane conditions for edge detection
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      los_d <= '0;
      fault_d <= '0;
    end else if (ce_i) begin
      los_d <= los_s;
      fault_d <= fault_s;
    end
  end

  // flag causes: entry into loss of signal, a new fault, init done
  always_comb begin
    flag_set = FLAGS_RST;
    flag_set[FLAG_LOS_BASE +: NUM_LANES] = los_s & ~los_d;
    flag_set[FLAG_FAULT_BASE +: NUM_LANES] = fault_s & ~fault_d;
    flag_set[FLAG_INIT_BIT] = init_done_pulse;
  end

  // sticky flags; a new event in the clearing cycle is kept
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      flags <= FLAGS_RST;
    end else if (ce_i) begin
      if (state == MSC_HELD) begin
        flags <= FLAGS_RST;
      end else if (commit) begin
        flags <= (flags & ~read_acc) | flag_set;
      end else begin
        flags <= flags | flag_set;
      end
    end
  end

  // mask and power-down bits, taken over on the committing edge
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      mask <= MASK_RST;
      pdown <= PDOWN_RST;
    end else if (ce_i) begin
      if (state == MSC_HELD) begin
        mask <= MASK_RST;
        pdown <= PDOWN_RST;
      end else if (commit) begin
        mask <= mask_wr_i;
        pdown <= pdown_wr_i;
      end
    end
  end

  // interrupt held low while any unmasked flag stays set
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      interrupt_out_n_o <= 1'b1;
    end else if (ce_i) begin
      interrupt_out_n_o <= !(|(flags & ~mask));
    end
  end

  // data-not-ready stays set until init completes
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      data_not_ready_o <= 1'b1;
    end else if (ce_i) begin
      data_not_ready_o <= (next_state != MSC_RUN);
    end
  end

  // bus answers only when running and selected
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      bus_enable_o <= 1'b0;
    end else if (ce_i) begin
      bus_enable_o <= (state == MSC_RUN) && !select_n_s;
    end
  end

  // low power from the pin or the software bit; clearing both restores at once
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      low_power_o <= 1'b0;
    end else if (ce_i) begin
      low_power_o <= lp_req_s || pdown;
    end
  end

  // presence is a constant low once out of reset
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      module_present_n_o <= 1'b0;
    end else if (ce_i) begin
      module_present_n_o <= 1'b0;
    end
  end

  // register copies for the host-visible map
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      flags_o <= FLAGS_RST;
      mask_o <= MASK_RST;
      pdown_o <= PDOWN_RST;
    end else if (ce_i) begin
      flags_o <= flags;
      mask_o <= mask;
      pdown_o <= pdown;
    end
  end

endmodule
`default_nettype wire
